/* rtl/cluster_pkg.sv */
/*
  Shared constants and types for the logic cluster: cell count, operating modes,
  register offsets and field layouts, per-cell configuration structs.
  Assumes a single 200 MHz system clock and a synchronous active-high reset.
*/
package cluster_pkg;

  localparam int unsigned NUM_CELLS = 10;
  localparam int unsigned NUM_GLOBALS = 4;
  localparam int unsigned ROW_W = 8;
  localparam int unsigned COL_W = 4;
  localparam int unsigned LUT_INPUTS = 4;
  localparam int unsigned PUSHBACK_EXTRA = 3;
  localparam int unsigned HALF_CELLS = 5;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned SYNC_STAGES = 2;

  // Source numbering seen by every data-input selector.
  localparam logic [SRC_W-1:0] SRC_GLOBAL0 = 5'h0A;
  localparam logic [SRC_W-1:0] SRC_ROW0 = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_COL0 = 5'h16;
  localparam logic [SRC_W-1:0] SRC_LAST = 5'h19;

  // Register map, byte addresses.
  localparam logic [11:0] OFS_CLUSTER_CTRL = 12'h000;
  localparam logic [11:0] OFS_GLOBAL_SRC = 12'h004;
  localparam logic [11:0] OFS_CELL_STATE = 12'h008;
  localparam logic [11:0] OFS_CELL_BUDGET = 12'h00C;
  localparam logic [11:0] OFS_CELL_CFG0 = 12'h040;
  localparam logic [11:0] OFS_CELL_ROUTE0 = 12'h080;
  localparam logic [11:0] CELL_BLOCK_SPAN = 12'h040;

  localparam logic [31:0] RST_CLUSTER_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_CELL_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_CELL_ROUTE = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ARITH,
    MODE_COUNTER,
    MODE_SPARE
  } cell_mode_t;

  typedef struct packed {
    logic [3:0]  reserved;
    logic        dual_emul;
    logic        out_from_reg;
    logic [3:0]  in_invert;
    logic        preset_inv;
    logic        clr_line_b;
    logic        casc_or;
    logic        casc_en;
    cell_mode_t  mode;
    logic [15:0] lut_mask;
  } cell_cfg_t;

  typedef struct packed {
    logic [11:0]      reserved;
    logic [SRC_W-1:0] sel_d;
    logic [SRC_W-1:0] sel_c;
    logic [SRC_W-1:0] sel_b;
    logic [SRC_W-1:0] sel_a;
  } cell_route_t;

  typedef struct packed {
    logic [14:0] reserved;
    logic [3:0]  global_internal;
    logic        dev_clr_en;
    logic        sload_en;
    logic        sclr_en;
    logic [1:0]  sload_sel;
    logic [1:0]  sclr_sel;
    logic [1:0]  line_b_sel;
    logic [1:0]  line_a_sel;
    logic [1:0]  clk_sel;
  } cluster_ctrl_t;

  // Cluster-wide register controls delivered to every cell.
  typedef struct packed {
    logic tick;
    logic line_a;
    logic line_b;
    logic sclr;
    logic sload;
    logic dev_clr;
  } cell_ctl_t;

endpackage

/* rtl/logic_cell.sv */
/*
  One logic cell: four-input lookup table, carry and cascade links, mode steering
  and a register with clear, load and preset-by-inversion.
  Assumes all controls are already synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module logic_cell (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire cluster_pkg::cell_cfg_t cfg,
  input  wire cluster_pkg::cell_ctl_t ctl,
  input  wire logic [3:0]             din,
  input  wire logic                   carry_in,
  input  wire logic                   casc_in,
  output var  logic                   reg_out,
  output var  logic                   comb_out,
  output var  logic                   carry_out,
  output var  logic                   casc_out
);
  import cluster_pkg::*;

  logic       q_q;
  logic       q_d;
  logic [3:0] lut_idx;
  logic       lut_val;
  logic       reg_in;
  logic       line_clr;

  // ****************************************************************
  // Mode steering of the seven inputs
  // ****************************************************************
  assign lut_idx = (cfg.mode == MODE_ARITH)   ? {carry_in, din[2:0]} :
                   (cfg.mode == MODE_COUNTER) ? {carry_in, q_q, din[1:0]} :
                                                din;
  assign lut_val = cfg.lut_mask[lut_idx];
  assign carry_out = (cfg.mode == MODE_ARITH) ?
                       ((din[0] & din[1]) | (carry_in & (din[0] | din[1]))) :
                     (cfg.mode == MODE_COUNTER) ? (q_q & carry_in) : 1'b0;
  assign casc_out = !cfg.casc_en ? lut_val :
                    cfg.casc_or ? (lut_val | casc_in) : (lut_val & casc_in);
  assign comb_out = casc_out;

  // ****************************************************************
  // Register with clear, load and preset emulation
  // ****************************************************************
  assign reg_in = casc_out ^ cfg.preset_inv;
  assign line_clr = cfg.clr_line_b ? ctl.line_b : ctl.line_a;
  assign q_d = ctl.dev_clr ? 1'b0 :
               line_clr ? 1'b0 :
               !ctl.tick ? q_q :
               ctl.sclr ? 1'b0 :
               ctl.sload ? (din[2] ^ cfg.preset_inv) : reg_in;
  assign reg_out = q_q ^ cfg.preset_inv;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_dev_clear_wins: assert property (@(posedge clk_sys) disable iff (srst)
    ctl.dev_clr |=> (q_q == 1'b0))
    else $error("device clear did not clear the cell register");
  a_preset_state: assert property (@(posedge clk_sys) disable iff (srst)
    (ctl.dev_clr && cfg.preset_inv && $stable(cfg.preset_inv)) |=> reg_out)
    else $error("preset register not in preset state under device clear");
  a_hold_no_tick: assert property (@(posedge clk_sys) disable iff (srst)
    (!ctl.tick && !ctl.dev_clr && !line_clr) |=> $stable(q_q))
    else $error("cell register changed without a clock tick");
  a_line_clear: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg.clr_line_b ? ctl.line_b : ctl.line_a) |=> !q_q)
    else $error("selected clear line did not clear the register");
  c_counter_carry: cover property (@(posedge clk_sys) disable iff (srst)
    cfg.mode == MODE_COUNTER && carry_out);
endmodule
`default_nettype wire

/* rtl/logic_cluster.sv */
/*
  Logic cluster top: ten cells, their carry and cascade chains, cluster-wide control
  lines, global input selection, local routing and a plain-port register file.
  Assumes pins are asynchronous to clk_sys and a register master on clk_sys.
*/
// The register addresses and the plain strobed port were decided locally.
// What this block does
// - A cluster holds ten cells, carry/cascade links, control lines and local routing.
// - Each cell has a four-input table realising any function of its inputs.
// - Each cell register feeds local routing and row/column routing.
// - Each cell runs in normal, arithmetic or counter mode.
// - Seven cell inputs are steered to destinations chosen by mode.
// - Shared lines give clock, asynchronous clear, sync clear and sync load.
// - Register clears from either control line, chosen by configuration.
// - Preset is clear with register input and output inverted; inputs invertible.
// - Enabled active-low device clear resets all registers, overriding everything.
// - Inversion-preset registers go to preset state under device clear.
// - Emulated preset-plus-clear or async load costs three extra cells.
// - Cells one to five drive right, six to ten drive left.
// - Inputs a and c come from the left, b and d from the right.
// - First and last cells drive one side only, like their neighbours; every cell reaches pins through route_out.
// - Global signals reach the cluster as clock, clear, preset or data.
// - Row routing links clusters and pins; column routing links rows.
// - Four low-skew global inputs, drivable from pins or internal logic.
`timescale 1ns/100ps
`default_nettype none
module logic_cluster (
  input  wire logic                                   clk_sys,
  input  wire logic                                   srst,
  input  wire logic [11:0]                            reg_addr,
  input  wire logic [31:0]                            reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output var  logic [31:0]                            reg_rdata,
  input  wire logic [cluster_pkg::NUM_GLOBALS-1:0]    global_in,
  input  wire logic                                   device_wide_clear_n,
  input  wire logic [cluster_pkg::ROW_W-1:0]          row_in,
  input  wire logic [cluster_pkg::COL_W-1:0]          col_in,
  input  wire logic                                   chain_carry_in,
  input  wire logic                                   chain_casc_in,
  output var  logic [cluster_pkg::NUM_CELLS-1:0]      route_out,
  output var  logic [cluster_pkg::NUM_GLOBALS-1:0]    global_out,
  output var  logic                                   chain_carry_out,
  output var  logic                                   chain_casc_out
);
  import cluster_pkg::*;

  localparam int unsigned PIN_W = NUM_GLOBALS + ROW_W + COL_W + 3;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // True when source s may feed cell i from the given side (1 = right side).
  function automatic logic src_legal(input int unsigned i, input logic right_side,
                                     input logic [SRC_W-1:0] s);
    int unsigned j;
    logic        ok;
    j = int'(s);
    ok = 1'b0;
    if (s > SRC_LAST) begin
      ok = 1'b0;
    end else if (j >= NUM_CELLS) begin
      ok = 1'b1;
    end else if (!right_side) begin
      ok = (j < i) && ((j < HALF_CELLS) || (j == NUM_CELLS - 1));
    end else begin
      ok = (j > i) && ((j >= HALF_CELLS) || (j == 0));
    end
    return ok;
  endfunction

  function automatic logic pick(input logic [31:0] srcs, input int unsigned i,
                                input logic right_side, input logic [SRC_W-1:0] s);
    return src_legal(i, right_side, s) ? srcs[s] : 1'b0;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [NUM_GLOBALS-1:0] gpin_s;
  logic [ROW_W-1:0]       row_s;
  logic [COL_W-1:0]       col_s;
  logic                   dev_clr_n_s;
  logic                   carry_in_s;
  logic                   casc_in_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {global_in, row_in, col_in, device_wide_clear_n, chain_carry_in, chain_casc_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign {gpin_s, row_s, col_s, dev_clr_n_s, carry_in_s, casc_in_s} = pin_sync_q;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  cluster_ctrl_t ctrl_q;
  logic [15:0]   gsrc_q;
  cell_cfg_t     cfg_q [NUM_CELLS];
  cell_route_t   route_cfg_q [NUM_CELLS];
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic          in_cfg_blk;
  logic          in_route_blk;
  logic [3:0]    cell_idx;
  logic          cell_idx_ok;
  logic [7:0]    budget;

  assign cell_idx = reg_addr[5:2];
  assign cell_idx_ok = (reg_addr[1:0] == 2'h0) && (cell_idx < 4'(NUM_CELLS));
  assign in_cfg_blk = (reg_addr[11:6] == OFS_CELL_CFG0[11:6]) && cell_idx_ok;
  assign in_route_blk = (reg_addr[11:6] == OFS_CELL_ROUTE0[11:6]) && cell_idx_ok;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= cluster_ctrl_t'(RST_CLUSTER_CTRL);
      gsrc_q <= '0;
      for (int i = 0; i < NUM_CELLS; i++) begin
        cfg_q[i] <= cell_cfg_t'(RST_CELL_CFG);
        route_cfg_q[i] <= cell_route_t'(RST_CELL_ROUTE);
      end
    end else if (reg_wr) begin
      if (reg_addr == OFS_CLUSTER_CTRL) begin
        ctrl_q <= cluster_ctrl_t'({15'h0000, reg_wdata[16:0]});
      end
      if (reg_addr == OFS_GLOBAL_SRC) begin
        gsrc_q <= reg_wdata[15:0];
      end
      if (in_cfg_blk) begin
        cfg_q[cell_idx] <= cell_cfg_t'({4'h0, reg_wdata[27:0]});
      end
      if (in_route_blk) begin
        route_cfg_q[cell_idx] <= cell_route_t'({12'h000, reg_wdata[19:0]});
      end
    end
  end

  // ****************************************************************
  // Global lines and cluster-wide controls
  // ****************************************************************
  logic [NUM_CELLS-1:0]   reg_out;
  logic [NUM_CELLS-1:0]   comb_out;
  logic [NUM_CELLS-1:0]   cell_out;
  logic [NUM_GLOBALS-1:0] glob_d;
  logic [NUM_GLOBALS-1:0] glob_q;
  logic                   clk_line_q;
  cell_ctl_t              ctl;
  logic [31:0]            srcs;

  for (genvar g = 0; g < NUM_GLOBALS; g++) begin : g_glob
    assign glob_d[g] = ctrl_q.global_internal[g] ? cell_out[gsrc_q[4*g +: 4]] : gpin_s[g];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      glob_q <= '0;
      clk_line_q <= 1'b0;
    end else begin
      glob_q <= glob_d;
      clk_line_q <= glob_q[ctrl_q.clk_sel];
    end
  end

  assign ctl.tick = glob_q[ctrl_q.clk_sel] && !clk_line_q;
  assign ctl.line_a = glob_q[ctrl_q.line_a_sel];
  assign ctl.line_b = glob_q[ctrl_q.line_b_sel];
  assign ctl.sclr = ctrl_q.sclr_en && glob_q[ctrl_q.sclr_sel];
  assign ctl.sload = ctrl_q.sload_en && glob_q[ctrl_q.sload_sel];
  assign ctl.dev_clr = ctrl_q.dev_clr_en && !dev_clr_n_s;

  assign srcs = {6'h00, col_s, row_s, glob_q, cell_out};

  // ****************************************************************
  // Cells with carry and cascade chains
  // ****************************************************************
  logic [NUM_CELLS:0] carry_chain;
  logic [NUM_CELLS:0] casc_chain;

  assign carry_chain[0] = carry_in_s;
  assign casc_chain[0] = casc_in_s;

  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    logic [3:0] din_raw;
    logic [3:0] din;
    assign din_raw[0] = pick(srcs, i, 1'b0, route_cfg_q[i].sel_a);
    assign din_raw[1] = pick(srcs, i, 1'b1, route_cfg_q[i].sel_b);
    assign din_raw[2] = pick(srcs, i, 1'b0, route_cfg_q[i].sel_c);
    assign din_raw[3] = pick(srcs, i, 1'b1, route_cfg_q[i].sel_d);
    assign din = din_raw ^ cfg_q[i].in_invert;
    assign cell_out[i] = cfg_q[i].out_from_reg ? reg_out[i] : comb_out[i];

    logic_cell u_cell (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .cfg       (cfg_q[i]),
      .ctl       (ctl),
      .din       (din),
      .carry_in  (carry_chain[i]),
      .casc_in   (casc_chain[i]),
      .reg_out   (reg_out[i]),
      .comb_out  (comb_out[i]),
      .carry_out (carry_chain[i+1]),
      .casc_out  (casc_chain[i+1])
    );
  end

  // ****************************************************************
  // Cell budget including push-back emulation cost
  // ****************************************************************
  always_comb begin
    budget = '0;
    for (int i = 0; i < NUM_CELLS; i++) begin
      budget = budget + 8'd1 + (cfg_q[i].dual_emul ? 8'(PUSHBACK_EXTRA) : 8'd0);
    end
  end

  // ****************************************************************
  // Read path and routing outputs
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == OFS_CLUSTER_CTRL) begin
      rdata_d = 32'(ctrl_q);
    end else if (reg_addr == OFS_GLOBAL_SRC) begin
      rdata_d = {16'h0000, gsrc_q};
    end else if (reg_addr == OFS_CELL_STATE) begin
      rdata_d = {8'h00, 4'(glob_q), comb_out, reg_out};
    end else if (reg_addr == OFS_CELL_BUDGET) begin
      rdata_d = {24'h00_0000, budget};
    end else if (in_cfg_blk) begin
      rdata_d = 32'(cfg_q[cell_idx]);
    end else if (in_route_blk) begin
      rdata_d = 32'(route_cfg_q[cell_idx]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= '0;
      route_out <= '0;
      global_out <= '0;
      chain_carry_out <= 1'b0;
      chain_casc_out <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
      route_out <= cell_out;
      global_out <= glob_q;
      chain_carry_out <= carry_chain[NUM_CELLS];
      chain_casc_out <= casc_chain[NUM_CELLS];
    end
  end
  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_read_latency: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == OFS_CELL_BUDGET) |=> (reg_rdata == {24'h00_0000, $past(budget)}))
    else $error("budget read did not return the cell budget");
  a_idle_read_zero: assert property (@(posedge clk_sys) disable iff (srst)
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data not zero after a cycle without read strobe");
  a_route_mirror: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> (route_out == $past(cell_out)))
    else $error("route outputs do not follow cell outputs by one cycle");
  a_dev_clr_path: assert property (@(posedge clk_sys) disable iff (srst)
    (ctrl_q.dev_clr_en && !$past(device_wide_clear_n)) |=> ctl.dev_clr)
    else $error("device clear not raised two stages after the pin");
  a_left_source: assert property (@(posedge clk_sys) disable iff (srst)
    (route_cfg_q[0].sel_a < SRC_GLOBAL0) |-> (g_cell[0].din_raw[0] == 1'b0))
    else $error("first cell took a cell source from its empty left side");
  a_tick_edge: assert property (@(posedge clk_sys) disable iff (srst)
    ctl.tick |=> !ctl.tick || $changed(ctrl_q.clk_sel))
    else $error("cluster clock tick lasted more than one cycle");
  a_carry_chain: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg_q[0].mode == MODE_NORMAL) |-> (carry_chain[1] == 1'b0))
    else $error("normal mode cell produced a carry");
  a_global_internal: assert property (@(posedge clk_sys) disable iff (srst)
    (ctrl_q.global_internal[0] && $stable(ctrl_q) && $stable(gsrc_q))
      |=> (glob_q[0] == $past(cell_out[gsrc_q[3:0]])))
    else $error("internally driven global did not follow its cell");
  a_global_out_delay: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> (global_out == $past(glob_q)))
    else $error("global outputs do not follow the global lines by one cycle");
  a_chain_outputs: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> ((chain_carry_out == $past(carry_chain[NUM_CELLS])) && (chain_casc_out == $past(casc_chain[NUM_CELLS]))))
    else $error("chain outputs do not follow the last cell by one cycle");
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && (reg_addr > OFS_CELL_BUDGET) && !in_cfg_blk && !in_route_blk) |=> (reg_rdata == 32'h0000_0000))
    else $error("read of an unmapped address returned nonzero data");
  a_right_source: assert property (@(posedge clk_sys) disable iff (srst)
    (route_cfg_q[9].sel_b < SRC_GLOBAL0) |-> (g_cell[9].din_raw[1] == 1'b0))
    else $error("last cell took a cell source from its empty right side");
  c_dev_clear: cover property (@(posedge clk_sys) disable iff (srst) ctl.dev_clr ##1 !ctl.dev_clr);
  c_arith_carry: cover property (@(posedge clk_sys) disable iff (srst) carry_chain[NUM_CELLS]);
  c_emul_budget: cover property (@(posedge clk_sys) disable iff (srst) budget > 8'd10);
endmodule
`default_nettype wire

/* verif/logic_cluster_tb_top.sv */
/*
  Self-checking bench for the logic cluster: register map, table function, carry
  input, local routing direction, register clock and clears, device clear.
  Assumes the cluster package and the design files are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module logic_cluster_tb_top;
  import cluster_pkg::*;
  logic        clk_sys             = 1'b0;
  logic        srst                = 1'b1;
  logic [11:0] reg_addr            = 12'h000;
  logic [31:0] reg_wdata           = 32'h0000_0000;
  logic        reg_wr              = 1'b0;
  logic        reg_rd              = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0]  global_in           = 4'h0;
  logic        device_wide_clear_n = 1'b1;
  logic [7:0]  row_in              = 8'h00;
  logic [3:0]  col_in              = 4'h0;
  logic        carry_in            = 1'b0;
  logic        casc_in             = 1'b0;
  logic [9:0]  route_out;
  logic [3:0]  global_out;
  logic        chain_carry_out;
  logic        chain_casc_out;
  int          bad_count           = 0;
  int          cmp_count           = 0;
  int          cyc                 = 0;
  logic [31:0] v;

  always #2.5 clk_sys = ~clk_sys;

  logic_cluster i_logic_cluster (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_in(global_in),
    .device_wide_clear_n(device_wide_clear_n), .row_in(row_in), .col_in(col_in),
    .chain_carry_in(carry_in), .chain_casc_in(casc_in), .route_out(route_out),
    .global_out(global_out), .chain_carry_out(chain_carry_out), .chain_casc_out(chain_casc_out)
  );

  // ****************************************************************
  // Bus and compare helpers
  // ****************************************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask

  task automatic probe(input int idx, input logic exp);
    wait_cyc(8);
    rd(OFS_CELL_STATE);
    chk({31'h0000_0000, v[idx]}, {31'h0000_0000, exp});
  endtask

  task automatic pulse_g0;
    global_in[0] <= 1'b1;
    wait_cyc(6);
    global_in[0] <= 1'b0;
    wait_cyc(6);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_map;
    rd(OFS_CLUSTER_CTRL); chk(v, 32'h0000_0000);
    rd(OFS_CELL_CFG0); chk(v, 32'h0000_0000);
    rd(OFS_CELL_ROUTE0); chk(v, 32'h0000_0000);
    rd(OFS_CELL_BUDGET); chk(v, 32'h0000_000A);
    wr(12'h068, 32'hFFFF_FFFF);
    rd(12'h068); chk(v, 32'h0000_0000);
    wr(12'h04C, 32'h0800_0000);
    rd(OFS_CELL_BUDGET); chk(v, 32'h0000_000D);
    wr(12'h04C, 32'h0000_0000);
  endtask

  task automatic t_lut;
    logic [15:0] mask;
    mask = 16'h6A5C;
    wr(OFS_CELL_ROUTE0, 32'h0008_C1EE);
    wr(OFS_CELL_CFG0, {16'h0000, mask});
    for (int i = 0; i < 16; i++) begin
      row_in <= 8'(i);
      probe(10, mask[i]);
      chk({31'h0000_0000, route_out[0]}, {31'h0000_0000, mask[i]});
    end
  endtask

  task automatic t_arith;
    wr(OFS_CELL_CFG0, 32'h0001_FF00);
    wr(12'h0A4, 32'h0000_01EE);
    wr(12'h064, 32'h0001_0000);
    for (int b = 1; b >= 0; b--) begin
      carry_in <= 1'(b);
      probe(10, 1'(b));
    end
    chk({31'h0000_0000, chain_carry_out}, 32'h0000_0001);
  endtask

  task automatic t_route;
    wr(OFS_CELL_CFG0, 32'h0000_FFFF);
    wr(12'h064, 32'h0000_FFFF);
    wr(12'h090, 32'h0000_0000);
    wr(12'h050, 32'h0000_AAAA);
    probe(14, 1'b1);
    wr(12'h050, 32'h0000_CCCC);
    probe(14, 1'b0);
    wr(12'h090, 32'h0000_0120);
    probe(14, 1'b1);
    chk({31'h0000_0000, chain_casc_out}, 32'h0000_0001);
  endtask

  task automatic t_regs;
    wr(OFS_CLUSTER_CTRL, 32'h0000_0024);
    wr(12'h084, 32'h0000_000E);
    wr(12'h088, 32'h0000_000F);
    wr(12'h044, 32'h0400_AAAA);
    wr(12'h048, 32'h0020_AAAA);
    row_in <= 8'h01;
    pulse_g0();
    rd(OFS_CELL_STATE); chk({30'h0, v[2:1]}, 32'h0000_0001);
    global_in[1] <= 1'b1;
    probe(1, 1'b0);
    global_in[1] <= 1'b0;
    pulse_g0();
    wr(12'h044, 32'h0410_AAAA);
    global_in[1] <= 1'b1;
    probe(1, 1'b1);
    chk({28'h000_0000, global_out}, 32'h0000_0002);
    global_in[1] <= 1'b0;
  endtask

  task automatic t_devclr;
    wr(OFS_CLUSTER_CTRL, 32'h0000_1024);
    pulse_g0();
    device_wide_clear_n <= 1'b0;
    wait_cyc(8);
    rd(OFS_CELL_STATE); chk({30'h0, v[2:1]}, 32'h0000_0002);
    pulse_g0();
    rd(OFS_CELL_STATE); chk({30'h0, v[2:1]}, 32'h0000_0002);
    device_wide_clear_n <= 1'b1;
    pulse_g0();
    rd(OFS_CELL_STATE); chk({30'h0, v[2:1]}, 32'h0000_0001);
  endtask

  // Globals 0 and 3 driven from cell 9, whose table is all ones.
  task automatic t_glob;
    wr(OFS_GLOBAL_SRC, 32'h0000_9009);
    wr(OFS_CLUSTER_CTRL, 32'h0001_2000);
    probe(20, 1'b1);
    probe(23, 1'b1);
    chk({28'h000_0000, global_out}, 32'h0000_0009);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    wait_cyc(20);
    srst <= 1'b0;
    wait_cyc(1);
    t_map();
    t_lut();
    t_arith();
    t_route();
    t_regs();
    t_devclr();
    t_glob();
    tally_and_finish();
  end
endmodule
`default_nettype wire
